// ==== core/ofd_cfg.svh ====
// register offsets, field layouts and reset values of the frequency window detectors
`ifndef OFD_CFG_SVH
`define OFD_CFG_SVH
`define OFD_FREQ_W       16
`define OFD_SEL_W        8
`define OFD_NUM_DO       3
`define OFD_NUM_DET      4
// register byte offsets
`define OFD_ADDR_CTRL    12'h000
`define OFD_ADDR_LVL2    12'h004
`define OFD_ADDR_WID2    12'h008
`define OFD_ADDR_LVL3    12'h00C
`define OFD_ADDR_WID3    12'h010
`define OFD_ADDR_LVL5    12'h014
`define OFD_ADDR_LVL6    12'h018
`define OFD_ADDR_SEL     12'h01C
`define OFD_ADDR_DET     12'h020
`define OFD_ADDR_ISTAT   12'h024
`define OFD_ADDR_IEN     12'h028
`define OFD_ADDR_ICLR    12'h02C
// selection codes
`define OFD_CODE_DET3    8'h32
`define OFD_CODE_DET4    8'h33
`define OFD_CODE_DET5    8'h34
`define OFD_CODE_DET6    8'h35
// ctrl fields
`define OFD_CTRL_ACCEL   0
`define OFD_CTRL_DECEL   1
`define OFD_RST_FREQ     16'h0000
`define OFD_RST_SEL      8'h00
// det6..det3 after reset: three and five off, their complements on
`define OFD_RST_DET      4'hA
`endif

// ==== core/ofd_hyst.sv ====
// one hysteretic detector: a single signal; its complement is formed in the top level
`include "ofd_cfg.svh"
module ofd_hyst
   import ofd_pkg::*;
(
   input  wire logic          clk_sys,
   input  wire logic          rstn,
   input  wire logic [15:0]   freq,
   input  wire ofd_dir_e      dir,
   input  wire ofd_thr_s      thr,
   output logic               det_q
);
   logic        det_d;
   logic [16:0] rise_sum;

   // widened so that level plus width never wraps
   assign rise_sum = {1'b0, thr.rise_lvl} + {1'b0, thr.rise_wid};

   always_comb begin
      det_d = det_q;
      case (dir)
         OFD_DIR_ACCEL: begin
            if ({1'b0, freq} > rise_sum) det_d = 1'b1;
         end
         OFD_DIR_DECEL: begin
            if (freq <= thr.fall_lvl) det_d = 1'b0;
         end
         default: det_d = det_q;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) det_q <= 1'b0;
      else       det_q <= det_d;
   end

   property p_hold;
      @(posedge clk_sys) disable iff (!rstn)
      (dir == OFD_DIR_STEADY) |=> $stable(det_q);
   endproperty
   a_hold: assert property (p_hold) else $error("detector changed while steady");

   property p_rise;
      @(posedge clk_sys) disable iff (!rstn)
      (dir == OFD_DIR_ACCEL && {1'b0, freq} > rise_sum) |=> det_q;
   endproperty
   a_rise: assert property (p_rise) else $error("detector not set on rise crossing");

   property p_fall;
      @(posedge clk_sys) disable iff (!rstn)
      (dir == OFD_DIR_DECEL && freq <= thr.fall_lvl) |=> !det_q;
   endproperty
   a_fall: assert property (p_fall) else $error("detector not cleared on fall crossing");
endmodule : ofd_hyst

// ==== core/ofd_pkg.sv ====
// types shared by the frequency window detector files
package ofd_pkg;
   typedef enum logic [1:0] {
      OFD_DIR_STEADY = 2'b00,
      OFD_DIR_ACCEL  = 2'b01,
      OFD_DIR_DECEL  = 2'b10
   } ofd_dir_e;

   typedef struct packed {
      logic [15:0] rise_lvl;
      logic [15:0] rise_wid;
      logic [15:0] fall_lvl;
   } ofd_thr_s;

   typedef logic [7:0] ofd_sel_t;
endpackage : ofd_pkg

// ==== core/ofd_top.sv ====
// frequency window detectors three to six with apb registers and output routing
`include "ofd_cfg.svh"
// Functional notes
// - det3 on when accelerating above level2+width2
// - det3 off when decelerating to level5
// - selector code 50 routes det3
// - det4 off when accelerating above level2+width2
// - det4 on when decelerating to level5
// - selector code 51 routes det4
// - det5 on when accelerating above level3+width3
// - det5 off when decelerating to level6
// - selector code 52 routes det5
// - det6 off when accelerating above level3+width3
// - det6 on when decelerating to level6
// - selector code 53 routes det6
module ofd_top
   import ofd_pkg::*;
(
   input  wire logic          clk_sys,
   input  wire logic          rstn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic [15:0]   out_freq,
   output logic      [2:0]    dout_q,
   output logic               irq_q
);
   ////////////////////////////////////////////////////////////////
   logic [15:0] lvl2_q, wid2_q, lvl3_q, wid3_q, lvl5_q, lvl6_q;
   logic [15:0] lvl2_d, wid2_d, lvl3_d, wid3_d, lvl5_d, lvl6_d;
   logic [1:0]  ctrl_q, ctrl_d;
   logic [7:0]  sel_q [3];
   logic [7:0]  sel_d [3];
   logic [3:0]  ien_q, ien_d, istat_q, istat_d;
   logic [31:0] prdata_d;
   logic        pready_d, pslverr_d;
   logic        wr_en, rd_en, hit;
   ofd_dir_e    dir;
   ofd_thr_s    thr_a, thr_b;
   logic        raw_a, raw_b;
   logic [3:0]  det, det_prev_q;
   logic [2:0]  dout_d;
   logic        irq_d;

   // access phase taken on the first penable cycle; answer one cycle later
   assign wr_en = psel && penable && !pready && pwrite;
   assign rd_en = psel && penable && !pready && !pwrite;

   // both direction bits set is treated as steady so nothing moves
   assign dir = (ctrl_q == 2'b01) ? OFD_DIR_ACCEL :
                (ctrl_q == 2'b10) ? OFD_DIR_DECEL : OFD_DIR_STEADY;

   assign thr_a = '{rise_lvl: lvl2_q, rise_wid: wid2_q, fall_lvl: lvl5_q};
   assign thr_b = '{rise_lvl: lvl3_q, rise_wid: wid3_q, fall_lvl: lvl6_q};

   ofd_hyst u_hyst_a (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .freq    (out_freq),
      .dir     (dir),
      .thr     (thr_a),
      .det_q   (raw_a)
   );

   ofd_hyst u_hyst_b (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .freq    (out_freq),
      .dir     (dir),
      .thr     (thr_b),
      .det_q   (raw_b)
   );

   // four and six are the complements of three and five
   assign det = {~raw_b, raw_b, ~raw_a, raw_a};

   ////////////////////////////////////////////////////////////////
   always_comb begin
      ctrl_d    = ctrl_q;
      lvl2_d    = lvl2_q;
      wid2_d    = wid2_q;
      lvl3_d    = lvl3_q;
      wid3_d    = wid3_q;
      lvl5_d    = lvl5_q;
      lvl6_d    = lvl6_q;
      sel_d     = sel_q;
      ien_d     = ien_q;
      hit       = 1'b1;
      prdata_d  = 32'h0000_0000;
      pready_d  = psel && penable && !pready;
      pslverr_d = 1'b0;
      case (paddr)
         `OFD_ADDR_CTRL: begin
            prdata_d = {30'h0000_0000, ctrl_q};
            if (wr_en) ctrl_d = pwdata[1:0];
         end
         `OFD_ADDR_LVL2: begin
            prdata_d = {16'h0000, lvl2_q};
            if (wr_en) lvl2_d = pwdata[15:0];
         end
         `OFD_ADDR_WID2: begin
            prdata_d = {16'h0000, wid2_q};
            if (wr_en) wid2_d = pwdata[15:0];
         end
         `OFD_ADDR_LVL3: begin
            prdata_d = {16'h0000, lvl3_q};
            if (wr_en) lvl3_d = pwdata[15:0];
         end
         `OFD_ADDR_WID3: begin
            prdata_d = {16'h0000, wid3_q};
            if (wr_en) wid3_d = pwdata[15:0];
         end
         `OFD_ADDR_LVL5: begin
            prdata_d = {16'h0000, lvl5_q};
            if (wr_en) lvl5_d = pwdata[15:0];
         end
         `OFD_ADDR_LVL6: begin
            prdata_d = {16'h0000, lvl6_q};
            if (wr_en) lvl6_d = pwdata[15:0];
         end
         `OFD_ADDR_SEL: begin
            prdata_d = {8'h00, sel_q[2], sel_q[1], sel_q[0]};
            if (wr_en) begin
               sel_d[0] = pwdata[7:0];
               sel_d[1] = pwdata[15:8];
               sel_d[2] = pwdata[23:16];
            end
         end
         `OFD_ADDR_DET: prdata_d = {25'h000_0000, dout_q, det};
         `OFD_ADDR_ISTAT: prdata_d = {28'h000_0000, istat_q};
         `OFD_ADDR_IEN: begin
            prdata_d = {28'h000_0000, ien_q};
            if (wr_en) ien_d = pwdata[3:0];
         end
         `OFD_ADDR_ICLR: prdata_d = 32'h0000_0000;
         default: hit = 1'b0;
      endcase
      if (!hit && pready_d) pslverr_d = 1'b1;
      if (!rd_en) prdata_d = 32'h0000_0000;
   end

   // sticky on any detector edge; a new edge wins over a clear in the same cycle
   always_comb begin
      istat_d = istat_q;
      if (wr_en && paddr == `OFD_ADDR_ICLR) istat_d = istat_q & ~pwdata[3:0];
      istat_d = istat_d | (det ^ det_prev_q);
      irq_d   = |(istat_d & ien_d);
   end

   ////////////////////////////////////////////////////////////////
   // output routing; unknown codes leave the output off
   always_comb begin
      for (int i = 0; i < `OFD_NUM_DO; i++) begin
         case (sel_q[i])
            `OFD_CODE_DET3: dout_d[i] = det[0];
            `OFD_CODE_DET4: dout_d[i] = det[1];
            `OFD_CODE_DET5: dout_d[i] = det[2];
            `OFD_CODE_DET6: dout_d[i] = det[3];
            default:        dout_d[i] = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         ctrl_q     <= 2'b00;
         lvl2_q     <= `OFD_RST_FREQ;
         wid2_q     <= `OFD_RST_FREQ;
         lvl3_q     <= `OFD_RST_FREQ;
         wid3_q     <= `OFD_RST_FREQ;
         lvl5_q     <= `OFD_RST_FREQ;
         lvl6_q     <= `OFD_RST_FREQ;
         sel_q      <= '{`OFD_RST_SEL, `OFD_RST_SEL, `OFD_RST_SEL};
         ien_q      <= 4'h0;
         istat_q    <= 4'h0;
         det_prev_q <= `OFD_RST_DET;
         prdata     <= 32'h0000_0000;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         dout_q     <= 3'h0;
         irq_q      <= 1'b0;
      end else begin
         ctrl_q     <= ctrl_d;
         lvl2_q     <= lvl2_d;
         wid2_q     <= wid2_d;
         lvl3_q     <= lvl3_d;
         wid3_q     <= wid3_d;
         lvl5_q     <= lvl5_d;
         lvl6_q     <= lvl6_d;
         sel_q      <= sel_d;
         ien_q      <= ien_d;
         istat_q    <= istat_d;
         det_prev_q <= det;
         prdata     <= prdata_d;
         pready     <= pready_d;
         pslverr    <= pslverr_d;
         dout_q     <= dout_d;
         irq_q      <= irq_d;
      end
   end

   ////////////////////////////////////////////////////////////////
   property p_det3_route;
      @(posedge clk_sys) disable iff (!rstn)
      (sel_q[0] == `OFD_CODE_DET3) |=> (dout_q[0] == $past(det[0]));
   endproperty
   a_det3_route: assert property (p_det3_route) else $error("code 50 not routed");

   property p_det4_route;
      @(posedge clk_sys) disable iff (!rstn)
      (sel_q[1] == `OFD_CODE_DET4) |=> (dout_q[1] == $past(det[1]));
   endproperty
   a_det4_route: assert property (p_det4_route) else $error("code 51 not routed");

   property p_det5_route;
      @(posedge clk_sys) disable iff (!rstn)
      (sel_q[2] == `OFD_CODE_DET5) |=> (dout_q[2] == $past(det[2]));
   endproperty
   a_det5_route: assert property (p_det5_route) else $error("code 52 not routed");

   property p_det6_route;
      @(posedge clk_sys) disable iff (!rstn)
      (sel_q[0] == `OFD_CODE_DET6) |=> (dout_q[0] == $past(det[3]));
   endproperty
   a_det6_route: assert property (p_det6_route) else $error("code 53 not routed");

   property p_det3_fall;
      @(posedge clk_sys) disable iff (!rstn)
      (dir == OFD_DIR_DECEL && out_freq <= lvl5_q) |=> (!det[0] && det[1]);
   endproperty
   a_det3_fall: assert property (p_det3_fall) else $error("det3/4 fall wrong");

   property p_det4_rise;
      @(posedge clk_sys) disable iff (!rstn)
      (dir == OFD_DIR_ACCEL && {1'b0, out_freq} > ({1'b0, lvl2_q} + {1'b0, wid2_q})) |=> !det[1];
   endproperty
   a_det4_rise: assert property (p_det4_rise) else $error("det4 not off on rise");

   property p_det5_rise;
      @(posedge clk_sys) disable iff (!rstn)
      (dir == OFD_DIR_ACCEL && {1'b0, out_freq} > ({1'b0, lvl3_q} + {1'b0, wid3_q})) |=> (det[2] && !det[3]);
   endproperty
   a_det5_rise: assert property (p_det5_rise) else $error("det5/6 rise wrong");

   property p_det6_fall;
      @(posedge clk_sys) disable iff (!rstn)
      (dir == OFD_DIR_DECEL && out_freq <= lvl6_q) |=> (det[3] && !det[2]);
   endproperty
   a_det6_fall: assert property (p_det6_fall) else $error("det5/6 fall wrong");

   property p_det3_rise;
      @(posedge clk_sys) disable iff (!rstn)
      (dir == OFD_DIR_ACCEL && {1'b0, out_freq} > ({1'b0, lvl2_q} + {1'b0, wid2_q})) |=> (det[0] && !det[1]);
   endproperty
   a_det3_rise: assert property (p_det3_rise) else $error("det3 not on at rise");

   property p_det4_fall;
      @(posedge clk_sys) disable iff (!rstn)
      (dir == OFD_DIR_DECEL && out_freq <= lvl5_q) |=> det[1];
   endproperty
   a_det4_fall: assert property (p_det4_fall) else $error("det4 not on at fall");

   property p_det5_fall;
      @(posedge clk_sys) disable iff (!rstn)
      (dir == OFD_DIR_DECEL && out_freq <= lvl6_q) |=> !det[2];
   endproperty
   a_det5_fall: assert property (p_det5_fall) else $error("det5 not off at fall");

   property p_det6_rise;
      @(posedge clk_sys) disable iff (!rstn)
      (dir == OFD_DIR_ACCEL && {1'b0, out_freq} > ({1'b0, lvl3_q} + {1'b0, wid3_q})) |=> !det[3];
   endproperty
   a_det6_rise: assert property (p_det6_rise) else $error("det6 not off at rise");

   // inside the window neither direction may move a detector
   property p_hold_a;
      @(posedge clk_sys) disable iff (!rstn)
      ((dir == OFD_DIR_ACCEL && {1'b0, out_freq} <= ({1'b0, lvl2_q} + {1'b0, wid2_q})) ||
       (dir == OFD_DIR_DECEL && out_freq > lvl5_q)) |=> $stable(det[1:0]);
   endproperty
   a_hold_a: assert property (p_hold_a) else $error("det3/4 moved inside window");

   property p_hold_b;
      @(posedge clk_sys) disable iff (!rstn)
      ((dir == OFD_DIR_ACCEL && {1'b0, out_freq} <= ({1'b0, lvl3_q} + {1'b0, wid3_q})) ||
       (dir == OFD_DIR_DECEL && out_freq > lvl6_q)) |=> $stable(det[3:2]);
   endproperty
   a_hold_b: assert property (p_hold_b) else $error("det5/6 moved inside window");

   property p_ready_pulse;
      @(posedge clk_sys) disable iff (!rstn)
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready held over one cycle");

   property p_err_with_ready;
      @(posedge clk_sys) disable iff (!rstn)
      pslverr |-> pready;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");

   property p_irq_level;
      @(posedge clk_sys) disable iff (!rstn)
      1'b1 |-> (irq_q == |(istat_q & ien_q));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq mismatch");
endmodule : ofd_top

// ==== verification/ofd_relay_model.sv ====
// relay and photo-coupler output stage that follows the multi-function outputs
module ofd_relay_model
   import ofd_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   input  wire logic [2:0] dout,
   output logic      [2:0] contact_q
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] contact_d;
   // normally open contacts; they close one tick after the drive asks, as a coil would lag
   always_comb begin
      contact_d = dout;
   end
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         contact_q <= 3'h0;
      end else begin
         contact_q <= contact_d;
      end
   end
endmodule : ofd_relay_model

// ==== verification/testbench.sv ====
// self-checking bench for the frequency window detectors
`include "ofd_cfg.svh"
module testbench
   import ofd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys;
   logic        rstn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [15:0] out_freq;
   logic [2:0]  dout_q;
   logic [2:0]  contact_q;
   logic        irq_q;
   logic [31:0] rd;
   logic        err;
   int          n_mismatch;
   int          compares;

   ofd_top uut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .out_freq(out_freq), .dout_q(dout_q), .irq_q(irq_q));
   ofd_relay_model relay (.clk_sys(clk_sys), .rstn(rstn), .dout(dout_q), .contact_q(contact_q));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("counts: compares=%0d mismatches=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // the slave's latency is not assumed; only the watchdog ends a wait that never answers
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // det nibble is det6..det3; dv is what outputs 2..0 must show
   task automatic step(input logic [15:0] f, input logic [3:0] det, input logic [2:0] dv);
      @(posedge clk_sys);
      out_freq <= f;
      repeat (2) @(posedge clk_sys);
      #1;
      check("dout", {29'h0, dout_q}, {29'h0, dv});
      apb(1'b0, `OFD_ADDR_DET, 32'h0);
      check("det", rd, {25'h0, dv, det});
   endtask : step

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      apb(1'b0, `OFD_ADDR_DET, 32'h0);
      check("det_reset", rd, 32'h0000000A);
      check("err_mapped", {31'h0, err}, 32'h0);
      check("irq_reset", {31'h0, irq_q}, 32'h0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_accel();
      apb(1'b1, `OFD_ADDR_LVL2, 32'h00000064);
      apb(1'b1, `OFD_ADDR_WID2, 32'h00000014);
      apb(1'b1, `OFD_ADDR_LVL5, 32'h00000032);
      apb(1'b1, `OFD_ADDR_LVL3, 32'h000000C8);
      apb(1'b1, `OFD_ADDR_WID3, 32'h0000001E);
      apb(1'b1, `OFD_ADDR_LVL6, 32'h00000096);
      apb(1'b1, `OFD_ADDR_SEL, 32'h00343332);
      apb(1'b1, `OFD_ADDR_IEN, 32'h00000001);
      apb(1'b1, `OFD_ADDR_CTRL, 32'h00000001);
      step(16'h0078, 4'hA, 3'b010);
      step(16'h0079, 4'h9, 3'b001);
      step(16'h00E6, 4'h9, 3'b001);
      step(16'h00E7, 4'h5, 3'b101);
      apb(1'b0, `OFD_ADDR_ISTAT, 32'h0);
      check("istat", rd, 32'h0000000F);
      check("irq_on", {31'h0, irq_q}, 32'h1);
      apb(1'b1, `OFD_ADDR_ICLR, 32'h0000000F);
      apb(1'b0, `OFD_ADDR_ISTAT, 32'h0);
      check("istat_clr", rd, 32'h0);
      check("irq_off", {31'h0, irq_q}, 32'h0);
      $display("test accel done");
   endtask : t_accel

   task automatic t_decel();
      apb(1'b1, `OFD_ADDR_CTRL, 32'h00000002);
      step(16'h0097, 4'h5, 3'b101);
      step(16'h0096, 4'h9, 3'b001);
      step(16'h0033, 4'h9, 3'b001);
      step(16'h0032, 4'hA, 3'b010);
      check("irq_again", {31'h0, irq_q}, 32'h1);
      apb(1'b1, `OFD_ADDR_IEN, 32'h0);
      apb(1'b0, `OFD_ADDR_ISTAT, 32'h0);
      check("istat_kept", rd, 32'h0000000F);
      check("irq_masked", {31'h0, irq_q}, 32'h0);
      // both direction bits, then neither: above every rise level nothing may move
      apb(1'b1, `OFD_ADDR_CTRL, 32'h00000003);
      step(16'h00FF, 4'hA, 3'b010);
      apb(1'b1, `OFD_ADDR_CTRL, 32'h00000000);
      step(16'h00FE, 4'hA, 3'b010);
      $display("test decel done");
   endtask : t_decel

   task automatic t_route();
      apb(1'b1, `OFD_ADDR_SEL, 32'h00000035);
      step(16'h0032, 4'hA, 3'b001);
      check("contact", {29'h0, contact_q}, 32'h1);
      apb(1'b0, 12'h100, 32'h0);
      check("unmapped_data", rd, 32'h0);
      check("unmapped_err", {31'h0, err}, 32'h1);
      $display("test route done");
   endtask : t_route

   // reset in mid-run: settings and sticky bits go back, no false edge follows
   task automatic t_rerun();
      @(posedge clk_sys);
      rstn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      apb(1'b0, `OFD_ADDR_SEL, 32'h0);
      check("sel_rerun", rd, 32'h0);
      apb(1'b0, `OFD_ADDR_ISTAT, 32'h0);
      check("istat_rerun", rd, 32'h0);
      apb(1'b0, `OFD_ADDR_DET, 32'h0);
      check("det_rerun", rd, 32'h0000000A);
      $display("test rerun done");
   endtask : t_rerun

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      n_mismatch++;
      close_out();
   end

   initial begin
      n_mismatch = 0;
      compares = 0;
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      out_freq = 16'h0000;
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      t_reset();
      t_accel();
      t_decel();
      t_route();
      t_rerun();
      close_out();
   end
endmodule : testbench
